// ### src/ext_volt_pkg.sv
/*
 External-voltage ADC control: register map, field positions, reset values, mode codes and
 timing constants shared by the control block and its helpers.
 Assumes one 10 MHz system clock.
*/
package ext_volt_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [1:0] mode_t;

    // Register addresses
    localparam byte_t ADDR_ADC_START   = 8'hD8;
    localparam byte_t ADDR_INT_ENABLE  = 8'hEC;
    localparam byte_t ADDR_RESULT      = 8'hEF;
    localparam byte_t ADDR_DELTA_CFG   = 8'hF3;
    localparam byte_t ADDR_INT_FLAGS   = 8'hF8;
    localparam byte_t ADDR_STROBE_PER  = 8'hF9;

    // Field positions
    localparam int START_BIT    = 2;
    localparam int DELTA_EN_BIT = 2;
    localparam int DELTA_FLAG_BIT = 2;
    localparam int DELTA_LSB    = 3;
    localparam int INTERVAL_LSB = 4;

    // Values after reset
    localparam byte_t RESULT_RST   = 8'h00;
    localparam byte_t ENABLE_RST   = 8'h00;
    localparam byte_t DELTA_RST    = 8'h00;
    localparam byte_t PERIOD_RST   = 8'h00;

    // Power-saving modes, as reported by the power manager
    localparam mode_t MODE_FULL    = 2'h0;
    localparam mode_t MODE_BATTERY = 2'h1;
    localparam mode_t MODE_SLEEP   = 2'h2;

    // Timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int TIMEBASE_US     = 1000;
    localparam int TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * TIMEBASE_US;
    localparam logic [7:0] PERIOD_TICKS_1 = 8'h01;
    localparam logic [7:0] PERIOD_TICKS_2 = 8'h08;
    localparam logic [7:0] PERIOD_TICKS_3 = 8'h40;

    // Control states, one-hot
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_e;

endpackage : ext_volt_pkg

// ### src/interval_timer.sv
/*
 Background interval timer: a slow timebase prescaler and an interval counter that pulses
 when a background conversion is due.
 Assumes an asynchronous active-low reset already released cleanly by the parent.
*/
`timescale 1ns/1ps
module interval_timer
    import ext_volt_pkg::*;
#(
    parameter int TICK_CYCLES = 10000
)(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic [1:0] interval,
    output logic            due
);

    // A single-cycle tick would leave the prescaler with no bits
    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    localparam int PW = $clog2(TICK_CYCLES);

    logic [PW-1:0] pre_q, pre_d;
    logic [7:0]    ticks_q, ticks_d;
    logic          due_q, due_d;

    function automatic logic [7:0] period_ticks(input logic [1:0] sel);
        unique case (sel)
            2'h1:    period_ticks = PERIOD_TICKS_1;
            2'h2:    period_ticks = PERIOD_TICKS_2;
            default: period_ticks = PERIOD_TICKS_3;
        endcase
    endfunction : period_ticks

    always_comb
    begin
        pre_d   = pre_q;
        ticks_d = ticks_q;
        due_d   = 1'b0;
        if (!enable || interval == 2'h0)
        begin
            pre_d   = '0;
            ticks_d = '0;
        end
        else if (pre_q == PW'(TICK_CYCLES - 1))
        begin
            pre_d = '0;
            if (ticks_q >= period_ticks(interval) - 8'h01)
            begin
                ticks_d = '0;
                due_d   = 1'b1;
            end
            else
            begin
                ticks_d = ticks_q + 8'h01;
            end
        end
        else
        begin
            pre_d = pre_q + PW'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q   <= '0;
            ticks_q <= '0;
            due_q   <= 1'b0;
        end
        else
        begin
            pre_q   <= pre_d;
            ticks_q <= ticks_d;
            due_q   <= due_d;
        end
    end

    assign due = due_q;

endmodule : interval_timer

// ### src/delta_detect.sv
/*
 Absolute-difference check between a new code and the reference code.
 Purely combinational; the parent registers whatever it derives from it.
*/
`timescale 1ns/1ps
module delta_detect
    import ext_volt_pkg::*;
(
    input  wire byte_t      new_code,
    input  wire byte_t      ref_code,
    input  wire logic [2:0] delta,
    output logic            exceeds
);

    byte_t diff;

    always_comb
    begin
        diff    = (new_code > ref_code) ? (new_code - ref_code) : (ref_code - new_code);
        exceeds = diff > {5'h00, delta};
    end

endmodule : delta_detect

// ### src/ext_voltage_adc_control.sv
/*
 External-voltage ADC control: register port, single and background conversion sequencing,
 delta check, result register and power-management flag.
 Assumes the analog converter raises conv_done with a stable conv_code after conv_req rises,
 and drops conv_done once conv_req falls; power_mode comes from logic on mclk.
*/
//
// Contract
// - Each result is an 8-bit unsigned code at 15.3 mV per step, held in the result register.
// - Setting the single-start bit runs one conversion, then updates the result and interrupts.
// - Background conversion is off after reset and runs only with a nonzero interval field.
// - After each background conversion the flag sets when |new - last interrupting| > delta.
// - The power-management interrupt comes from the flag only while its enable bit is set.
// - In full-power mode both single and background conversions are served.
// - In battery mode single conversions are served but background ones are not.
// - In sleep mode only background conversions take place.
// - The result register loads only when an ADC interrupt occurs.
// - The ADC interrupt fires on a delta excess or a finished single conversion, no flag.
`timescale 1ns/1ps
module ext_voltage_adc_control
    import ext_volt_pkg::*;
#(
    parameter int TICK_CYCLES = ext_volt_pkg::TICK_CYCLES_DEF
)(
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire ext_volt_pkg::byte_t sfr_addr,
    input  wire logic                sfr_wr_en,
    input  wire logic                sfr_rd_en,
    input  wire ext_volt_pkg::byte_t sfr_wdata,
    output ext_volt_pkg::byte_t      sfr_rdata,
    input  wire ext_volt_pkg::mode_t power_mode,
    output logic                     conv_req,
    input  wire logic                conv_done,
    input  wire ext_volt_pkg::byte_t conv_code,
    output logic                     adc_int,
    output logic                     psm_int
);

    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // Reset release
    logic rst_s1_q, rst_n;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Converter inputs come from the analog side; first stage feeds only the second
    logic  done_s1_q, done_s2_q, done_s3_q;
    byte_t code_s1_q, code_s2_q;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
            code_s1_q <= '0;
            code_s2_q <= '0;
        end
        else
        begin
            done_s1_q <= conv_done;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            code_s1_q <= conv_code;
            code_s2_q <= code_s1_q;
        end
    end

    logic done_rise;
    assign done_rise = done_s2_q & ~done_s3_q;

    conv_state_e st_q, st_d;
    byte_t       result_q, result_d;
    byte_t       enable_q, enable_d;
    byte_t       delta_q, delta_d;
    byte_t       period_q, period_d;
    byte_t       rdata_q, rdata_d;
    logic        flag_q, flag_d;
    logic        single_pend_q, single_pend_d;
    logic        bg_pend_q, bg_pend_d;
    logic        src_single_q, src_single_d;
    logic        req_q, req_d;
    logic        adc_int_q, adc_int_d;
    logic        psm_int_q, psm_int_d;
    logic        start_single, start_bg;
    logic        bg_allowed, bg_due, exceeds;
    logic [1:0]  interval;
    logic [2:0]  delta_set;

    assign interval  = period_q[INTERVAL_LSB +: 2];
    assign delta_set = delta_q[DELTA_LSB +: 3];
    // Battery mode has no background service; full and sleep do
    assign bg_allowed = (interval != 2'h0) && (power_mode != MODE_BATTERY);

    interval_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (bg_allowed),
        .interval (interval),
        .due      (bg_due)
    );

    // Reference is the last code that interrupted, which is the result register itself
    delta_detect u_delta (
        .new_code (code_s2_q),
        .ref_code (result_q),
        .delta    (delta_set),
        .exceeds  (exceeds)
    );

    always_comb
    begin
        st_d          = st_q;
        result_d      = result_q;
        enable_d      = enable_q;
        delta_d       = delta_q;
        period_d      = period_q;
        flag_d        = flag_q;
        single_pend_d = single_pend_q;
        bg_pend_d     = bg_pend_q;
        src_single_d  = src_single_q;
        req_d         = req_q;
        adc_int_d     = 1'b0;
        start_single  = 1'b0;
        start_bg      = 1'b0;
        rdata_d       = rdata_q;

        // Software clear first so a same-cycle set below wins
        if (sfr_wr_en)
        begin
            case (sfr_addr)
                ADDR_INT_ENABLE: enable_d = sfr_wdata;
                ADDR_DELTA_CFG:  delta_d  = sfr_wdata;
                ADDR_STROBE_PER: period_d = sfr_wdata;
                ADDR_INT_FLAGS:
                begin
                    if (!sfr_wdata[DELTA_FLAG_BIT])
                    begin
                        flag_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        if (bg_due)
        begin
            bg_pend_d = 1'b1;
        end
        if (!bg_allowed)
        begin
            bg_pend_d = 1'b0;
        end
        if (power_mode == MODE_SLEEP)
        begin
            single_pend_d = 1'b0;
        end

        unique case (st_q)
            ST_IDLE:
            begin
                if (single_pend_q && power_mode != MODE_SLEEP)
                begin
                    start_single  = 1'b1;
                    single_pend_d = 1'b0;
                    src_single_d  = 1'b1;
                    req_d         = 1'b1;
                    st_d          = ST_CONV;
                end
                else if (bg_pend_q && bg_allowed)
                begin
                    start_bg     = 1'b1;
                    bg_pend_d    = 1'b0;
                    src_single_d = 1'b0;
                    req_d        = 1'b1;
                    st_d         = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (done_rise)
                begin
                    req_d = 1'b0;
                    st_d  = ST_IDLE;
                    if (src_single_q || exceeds)
                    begin
                        result_d  = code_s2_q;
                        adc_int_d = 1'b1;
                    end
                    if (!src_single_q && exceeds)
                    begin
                        flag_d = 1'b1;
                    end
                end
            end
            default:
            begin
                req_d = 1'b0;
                st_d  = ST_IDLE;
            end
        endcase

        // A start written while the previous one is consumed is kept
        if (sfr_wr_en && sfr_addr == ADDR_ADC_START && sfr_wdata[START_BIT]
            && power_mode != MODE_SLEEP)
        begin
            single_pend_d = 1'b1;
        end

        psm_int_d = flag_q & enable_q[DELTA_EN_BIT];

        if (sfr_rd_en)
        begin
            case (sfr_addr)
                ADDR_ADC_START:
                begin
                    rdata_d = '0;
                    rdata_d[START_BIT] = single_pend_q | (st_q == ST_CONV && src_single_q);
                end
                ADDR_INT_ENABLE: rdata_d = enable_q;
                ADDR_RESULT:     rdata_d = result_q;
                ADDR_DELTA_CFG:  rdata_d = delta_q;
                ADDR_STROBE_PER: rdata_d = period_q;
                ADDR_INT_FLAGS:
                begin
                    rdata_d = '0;
                    rdata_d[DELTA_FLAG_BIT] = flag_q;
                end
                default:         rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q          <= ST_IDLE;
            result_q      <= RESULT_RST;
            enable_q      <= ENABLE_RST;
            delta_q       <= DELTA_RST;
            period_q      <= PERIOD_RST;
            flag_q        <= 1'b0;
            single_pend_q <= 1'b0;
            bg_pend_q     <= 1'b0;
            src_single_q  <= 1'b0;
            req_q         <= 1'b0;
            adc_int_q     <= 1'b0;
            psm_int_q     <= 1'b0;
            rdata_q       <= '0;
        end
        else
        begin
            st_q          <= st_d;
            result_q      <= result_d;
            enable_q      <= enable_d;
            delta_q       <= delta_d;
            period_q      <= period_d;
            flag_q        <= flag_d;
            single_pend_q <= single_pend_d;
            bg_pend_q     <= bg_pend_d;
            src_single_q  <= src_single_d;
            req_q         <= req_d;
            adc_int_q     <= adc_int_d;
            psm_int_q     <= psm_int_d;
            rdata_q       <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign conv_req  = req_q;
    assign adc_int   = adc_int_q;
    assign psm_int   = psm_int_q;

    a_single_result: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q == ST_CONV && src_single_q && done_rise)
        |=> adc_int_q && result_q == $past(code_s2_q) && st_q == ST_IDLE)
        else $error("single conversion did not load result and interrupt");

    a_result_only_int: assert property (@(posedge mclk) disable iff (!rst_n)
        (result_q != $past(result_q)) |-> adc_int_q)
        else $error("result changed without an ADC interrupt");

    a_int_cause: assert property (@(posedge mclk) disable iff (!rst_n)
        adc_int_q |-> $past(done_rise) && ($past(src_single_q) || $past(exceeds)))
        else $error("ADC interrupt without a cause");

    a_bg_needs_interval: assert property (@(posedge mclk) disable iff (!rst_n)
        start_bg |-> interval != 2'h0)
        else $error("background conversion with zero interval");

    a_battery_no_bg: assert property (@(posedge mclk) disable iff (!rst_n)
        (power_mode == MODE_BATTERY) |-> !start_bg)
        else $error("background conversion in battery mode");

    a_sleep_no_single: assert property (@(posedge mclk) disable iff (!rst_n)
        (power_mode == MODE_SLEEP) |-> !start_single)
        else $error("single conversion in sleep mode");

    a_delta_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q == ST_CONV && !src_single_q && done_rise && exceeds) |=> flag_q ##1 psm_int_q
        || !$past(enable_q[DELTA_EN_BIT]))
        else $error("delta excess did not set the flag");

    a_psm_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        psm_int_q |-> $past(flag_q) && $past(enable_q[DELTA_EN_BIT]))
        else $error("power interrupt without enabled flag");

    a_full_bg_start: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q == ST_IDLE && bg_pend_q && bg_allowed && !single_pend_q
         && power_mode == MODE_FULL) |=> st_q == ST_CONV && conv_req)
        else $error("background conversion not started in full power");

endmodule : ext_voltage_adc_control

// ### sim/ext_voltage_adc_control_test.sv
/*
 Self-checking bench for the external-voltage ADC control block: register access, single and
 background conversions, delta flag, power modes, with a behavioural converter on the far side.
 Assumes ext_volt_pkg is compiled first; the slow tick is shortened to keep the run brief.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t: got %0h expected %0h", $time, (a), (b)); end end
module ext_voltage_adc_control_test;
    import ext_volt_pkg::*;

    localparam int TICK  = 4;
    localparam int LIMIT = 30000;

    logic        mclk;
    logic        rstn;
    logic        sfr_wr_en;
    logic        sfr_rd_en;
    logic        conv_done;
    logic        conv_req;
    logic        adc_int;
    logic        psm_int;
    byte_t       sfr_addr;
    byte_t       sfr_wdata;
    byte_t       sfr_rdata;
    byte_t       conv_code;
    mode_t       power_mode;
    int          mismatches;
    int          samples_checked;
    int          cycles;
    int          act_ints;
    int          exp_ints;
    int          n_conv;
    logic [31:0] seed;
    logic        single_req;
    logic        exp_flag;
    logic        en;
    byte_t       ref_code;
    logic [2:0]  dlt;
    byte_t       regs [7] = '{ADDR_ADC_START, ADDR_INT_ENABLE, ADDR_RESULT, ADDR_DELTA_CFG,
                              ADDR_INT_FLAGS, ADDR_STROBE_PER, 8'h80};

    ext_voltage_adc_control #(
        .TICK_CYCLES (TICK)
    ) u_dut (
        .mclk       (mclk),
        .rstn       (rstn),
        .sfr_addr   (sfr_addr),
        .sfr_wr_en  (sfr_wr_en),
        .sfr_rd_en  (sfr_rd_en),
        .sfr_wdata  (sfr_wdata),
        .sfr_rdata  (sfr_rdata),
        .power_mode (power_mode),
        .conv_req   (conv_req),
        .conv_done  (conv_done),
        .conv_code  (conv_code),
        .adc_int    (adc_int),
        .psm_int    (psm_int)
    );

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Background codes wander a few steps around the reference, clamped to the code range
    function automatic byte_t near(byte_t c, logic [31:0] r);
        int t;
        t = int'(c) + int'(r % 15) - 7;
        if (t < 0) t = 0;
        if (t > 255) t = 255;
        return byte_t'(t);
    endfunction : near

    function automatic logic over(byte_t a, byte_t b, logic [2:0] d);
        int df;
        df = int'(a) - int'(b);
        if (df < 0) df = -df;
        return df > int'(d);
    endfunction : over

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic wr(input byte_t a, input byte_t d);
        @(posedge mclk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr_en <= 1'b1;
        @(posedge mclk);
        sfr_wr_en <= 1'b0;
    endtask : wr

    task automatic rchk(input byte_t a, input byte_t e);
        @(posedge mclk);
        sfr_addr  <= a;
        sfr_rd_en <= 1'b1;
        @(posedge mclk);
        sfr_rd_en <= 1'b0;
        @(negedge mclk);
        `CHK(sfr_rdata, e)
    endtask : rchk

    task automatic wait_conv(input int k);
        int target;
        target = n_conv + k;
        for (int i = 0; i < 4000 && n_conv < target; i++) @(posedge mclk);
        `CHK(n_conv >= target, 1'b1)
    endtask : wait_conv

    // Stopping the interval lets any conversion in flight finish before registers are read
    task automatic quiet();
        wr(ADDR_STROBE_PER, 8'h00);
        repeat (40) @(posedge mclk);
    endtask : quiet

    always @(posedge mclk)
    begin
        cycles++;
        if (adc_int === 1'b1) act_ints++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            final_report();
        end
    end

    // Converter: code settles well before done, done drops only after the request falls
    initial
    begin : converter
        byte_t code;
        logic  is_s;
        conv_done = 1'b0;
        conv_code = 8'h00;
        forever
        begin
            @(negedge mclk);
            if (conv_req === 1'b1)
            begin
                is_s = single_req;
                single_req = 1'b0;
                code = is_s ? byte_t'(xs()) : near(ref_code, xs());
                @(posedge mclk);
                conv_code <= code;
                repeat (3 + xs() % 6) @(posedge mclk);
                conv_done <= 1'b1;
                do @(negedge mclk); while (conv_req !== 1'b0);
                @(posedge mclk);
                conv_done <= 1'b0;
                conv_code <= ~code;
                if (is_s || over(code, ref_code, dlt))
                begin
                    exp_ints++;
                    ref_code = code;
                    exp_flag = exp_flag | !is_s;
                end
                repeat (2) @(posedge mclk);
                `CHK(act_ints, exp_ints)
                n_conv++;
            end
        end
    end

    initial
    begin : main
        byte_t v;
        int    k;
        int    need;
        seed = 32'hAC5E;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        act_ints = 0;
        exp_ints = 0;
        n_conv = 0;
        rstn = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr_en = 1'b0;
        sfr_rd_en = 1'b0;
        power_mode = MODE_FULL;
        single_req = 1'b0;
        exp_flag = 1'b0;
        en = 1'b0;
        ref_code = RESULT_RST;
        dlt = 3'h0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (regs[i]) rchk(regs[i], 8'h00);
        `CHK({conv_req, psm_int}, 2'b00)
        for (int i = 0; i < 4; i++)
        begin
            v = byte_t'(xs());
            wr(ADDR_INT_ENABLE, v);
            rchk(ADDR_INT_ENABLE, v);
            wr(ADDR_DELTA_CFG, v);
            rchk(ADDR_DELTA_CFG, v);
            wr(ADDR_STROBE_PER, v & 8'hCF);
            rchk(ADDR_STROBE_PER, v & 8'hCF);
            wr(ADDR_RESULT, v);
            rchk(ADDR_RESULT, ref_code);
        end
        wr(ADDR_INT_FLAGS, 8'hFF);
        rchk(ADDR_INT_FLAGS, 8'h00);
        wr(8'h80, 8'hFF);
        rchk(8'h80, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge mclk) power_mode <= m ? MODE_BATTERY : MODE_FULL;
            for (int i = 0; i < 3; i++)
            begin
                single_req = 1'b1;
                wr(ADDR_ADC_START, 8'h04);
                rchk(ADDR_ADC_START, 8'h04);
                wait_conv(1);
                rchk(ADDR_RESULT, ref_code);
                rchk(ADDR_ADC_START, 8'h00);
            end
        end
        @(posedge mclk) power_mode <= MODE_SLEEP;
        k = n_conv;
        wr(ADDR_ADC_START, 8'h04);
        rchk(ADDR_ADC_START, 8'h00);
        repeat (40) @(posedge mclk);
        `CHK(n_conv, k)
        v = byte_t'(xs());
        // Delta 0 and 7 are the boundaries of the strict comparison
        for (int p = 0; p < 3; p++)
        begin
            @(posedge mclk) power_mode <= (p == 1) ? MODE_SLEEP : MODE_FULL;
            dlt = (p == 0) ? 3'h0 : (p == 1) ? 3'h7 : v[2:0];
            en = (p != 2);
            // Each due comes a full period after the last one
            need = ((p == 2) ? 2 : 10) * TICK * int'((p == 0) ? PERIOD_TICKS_1 :
                   (p == 1) ? PERIOD_TICKS_2 : PERIOD_TICKS_3);
            // Singles above came first; delta goes in before the interval
            wr(ADDR_DELTA_CFG, {2'b00, dlt, 3'b000});
            wr(ADDR_INT_ENABLE, {5'h00, en, 2'b00});
            wr(ADDR_STROBE_PER, {2'b00, 2'(p + 1), 4'h0});
            k = cycles;
            wait_conv((p == 2) ? 2 : 10);
            `CHK((cycles - k) >= need, 1'b1)
            quiet();
            rchk(ADDR_RESULT, ref_code);
            rchk(ADDR_INT_FLAGS, {5'h00, exp_flag, 2'b00});
            `CHK(psm_int, exp_flag & en)
            wr(ADDR_INT_FLAGS, 8'h00);
            exp_flag = 1'b0;
            rchk(ADDR_INT_FLAGS, 8'h00);
            `CHK(psm_int, 1'b0)
        end
        @(posedge mclk) power_mode <= MODE_BATTERY;
        k = n_conv;
        wr(ADDR_STROBE_PER, 8'h10);
        repeat (60) @(posedge mclk);
        `CHK(n_conv, k)
        final_report();
    end

endmodule : ext_voltage_adc_control_test
